// ===== rtl/sms_sfr_area_map_select.sv
`timescale 1ns/10ps

// How it works
// R1: Map-select bit clear routes every register access to the standard area; reset clears it.
// R2: Map-select bit set routes accesses to the mapped area instead.
// R3: Hardware never clears the map-select bit outside reset; only a software write does.
// R4: Only second power control and port 5 direction decode in the mapped area.
// R5: System control register sits at b1 hex with variant-specific reset pattern.
// R6: All processor registers except program counter and four banks live here.
// R7: Standard and mapped areas together hold 59 registers.
// R8: Emulation controls the device and reports execution over ports 0, 2.
// R9: Emulator may single-step the device and read registers after a break.
// R10: Data pointer select sits at 92 hex, resetting to XXXXX000.
// R11: Reading the map-select bit returns the last written or reset value.
module sms_sfr_area_map_select
    import sms_pkg::*;
#(
    parameter bit         OTP_VARIANT          = 1'b0,
    parameter logic [7:0] POWER_CONTROL_SECOND = POWER_CONTROL_SECOND_DEF,
    parameter logic [7:0] PORT5_DIRECTION      = PORT5_DIRECTION_DEF,
    parameter int         SFR_COUNT            = SFR_COUNT_DEF
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire sms_req_t   cpu_req,
    output sms_sel_t        cpu_sel,
    output logic            sfr_map_select,
    input  wire logic [7:0] periph_rdata,
    output logic [7:0]      cpu_rdata,
    output logic [2:0]      data_pointer_select,
    input  wire logic       emu_break_pin,
    input  wire logic       emu_step_pin,
    input  wire logic [7:0] emu_rd_addr,
    input  wire logic       emu_rd,
    output sms_sel_t        emu_sel,
    output logic [7:0]      emu_rdata,
    output logic            cpu_run,
    output logic            emu_halted
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The register count is fixed by the device; other sizes are not served.
    if (SFR_COUNT != SFR_COUNT_DEF) begin : g_bad_count
        $error("sfr count must be 59"); // R7
    end
    if (POWER_CONTROL_SECOND == PORT5_DIRECTION) begin : g_bad_map
        $error("mapped registers need distinct addresses");
    end

    // A mapped register placed on a local address would hide that register while
    // the map bit is set; on the system control address, software could then never clear the bit again.
    function automatic logic clashes_local(input logic [7:0] addr);
        return (addr == SYSTEM_CONTROL_ADDR) || (addr == DATA_POINTER_SELECT_ADDR);
    endfunction
    if (clashes_local(POWER_CONTROL_SECOND)) begin : g_bad_pcs
        $error("second power control address hides a local register");
    end
    if (clashes_local(PORT5_DIRECTION)) begin : g_bad_p5
        $error("port 5 direction address hides a local register");
    end

    // The mask of state-holding bits differs between the variants; both reset patterns load 21 hex.
    localparam logic [7:0] SC_RESET = OTP_VARIANT ? SYSTEM_CONTROL_RESET_OTP
                                                  : SYSTEM_CONTROL_RESET_ROM;
    localparam logic [7:0] SC_IMPL  = OTP_VARIANT ? SYSTEM_CONTROL_IMPL_OTP
                                                  : SYSTEM_CONTROL_IMPL_ROM;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    // Shared by the CPU port and the emulator readout so both see one map.
    function automatic sms_sel_t decode(input logic [7:0] addr, input logic map_sel);
        sms_sel_t s;
        s.sel_power_control_second = map_sel && (addr == POWER_CONTROL_SECOND); // R2 R4
        s.sel_port5_direction      = map_sel && (addr == PORT5_DIRECTION);      // R2 R4
        s.sel_standard = !(s.sel_power_control_second || s.sel_port5_direction); // R1 R4
        return s;
    endfunction

    // A local register answers only while the standard area is decoded for it.
    function automatic logic local_hit(input logic [7:0] addr, input sms_sel_t s,
                                       input logic [7:0] target);
        return s.sel_standard && (addr == target);
    endfunction

    // Local registers answer only in the standard area.
    function automatic logic [7:0] local_read(input logic [7:0] addr, input sms_sel_t s,
                                              input logic [7:0] sc, input logic [7:0] dp,
                                              input logic [7:0] ext);
        logic [7:0] r;
        r = ext;
        if (local_hit(addr, s, SYSTEM_CONTROL_ADDR)) begin
            r = sc; // R5 R11
        end else if (local_hit(addr, s, DATA_POINTER_SELECT_ADDR)) begin
            r = dp; // R10
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] system_control_ff;
    logic [7:0] nxt_system_control;
    logic [7:0] ptr_sel_ff;
    logic [7:0] nxt_ptr_sel;
    logic [7:0] cpu_rdata_ff;
    logic [7:0] nxt_cpu_rdata;
    logic [7:0] emu_rdata_ff;
    logic [7:0] nxt_emu_rdata;

    // The emulator decodes with the CPU's map bit, so a readout after a break
    // shows each register exactly as the program would have reached it.
    assign sfr_map_select      = system_control_ff[SFR_MAP_SELECT_BIT];
    assign cpu_sel             = decode(cpu_req.addr, sfr_map_select);
    assign emu_sel             = decode(emu_rd_addr, sfr_map_select);
    assign data_pointer_select = ptr_sel_ff[2:0];
    assign cpu_rdata           = cpu_rdata_ff;
    assign emu_rdata           = emu_rdata_ff;

    // Writes land only when the standard area is decoded; outside reset the map bit changes
    // solely here, never by any other hardware event.
    always_comb begin
        nxt_system_control = system_control_ff; // R3
        nxt_ptr_sel        = ptr_sel_ff;
        nxt_cpu_rdata      = cpu_rdata_ff;
        nxt_emu_rdata      = emu_rdata_ff;
        if (cpu_req.wr && local_hit(cpu_req.addr, cpu_sel, SYSTEM_CONTROL_ADDR)) begin
            nxt_system_control = cpu_req.wdata & SC_IMPL; // R5 R11
        end
        if (cpu_req.wr && local_hit(cpu_req.addr, cpu_sel, DATA_POINTER_SELECT_ADDR)) begin
            nxt_ptr_sel = cpu_req.wdata & DATA_POINTER_SELECT_IMPL; // R10
        end
        if (cpu_req.rd) begin
            nxt_cpu_rdata = local_read(cpu_req.addr, cpu_sel, system_control_ff,
                                       ptr_sel_ff, periph_rdata); // R6
        end
        // Readout is only offered while halted, so it never races the program.
        if (emu_rd && emu_halted) begin
            nxt_emu_rdata = local_read(emu_rd_addr, emu_sel, system_control_ff,
                                       ptr_sel_ff, periph_rdata); // R9
        end
    end

    // Masked bits reset to zero and stay zero, so software always reads them
    // back as zero whatever it wrote.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            system_control_ff <= SC_RESET; // R1 R5
            ptr_sel_ff        <= DATA_POINTER_SELECT_RESET; // R10
            cpu_rdata_ff      <= 8'h00;
            emu_rdata_ff      <= 8'h00;
        end else begin
            system_control_ff <= nxt_system_control;
            ptr_sel_ff        <= nxt_ptr_sel;
            cpu_rdata_ff      <= nxt_cpu_rdata;
            emu_rdata_ff      <= nxt_emu_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Emulation control
    // ------------------------------------------------------------------
    // Pins from the emulation hardware are asynchronous, so each passes two
    // flip-flops; the step request is edge-detected after that.
    logic [1:0] brk_sync_ff;
    logic [1:0] nxt_brk_sync;
    logic [1:0] stp_sync_ff;
    logic [1:0] nxt_stp_sync;
    logic       stp_prev_ff;
    logic       nxt_stp_prev;
    sms_emu_t   emu_state_ff;
    sms_emu_t   nxt_emu_state;
    logic       step_edge;

    assign step_edge  = stp_sync_ff[1] && !stp_prev_ff;
    assign cpu_run    = (emu_state_ff == SMS_RUN) || (emu_state_ff == SMS_STEP); // R8
    assign emu_halted = (emu_state_ff == SMS_BREAK);

    // A step lets exactly one cycle through, then the device halts again.
    always_comb begin
        nxt_brk_sync  = {brk_sync_ff[0], emu_break_pin};
        nxt_stp_sync  = {stp_sync_ff[0], emu_step_pin};
        nxt_stp_prev  = stp_sync_ff[1];
        nxt_emu_state = emu_state_ff;
        case (emu_state_ff)
            SMS_RUN: begin
                if (brk_sync_ff[1]) begin
                    nxt_emu_state = SMS_BREAK; // R8
                end
            end
            SMS_BREAK: begin
                if (!brk_sync_ff[1]) begin
                    nxt_emu_state = SMS_RUN;
                end else if (step_edge) begin
                    nxt_emu_state = SMS_STEP; // R9
                end
            end
            SMS_STEP: begin
                nxt_emu_state = SMS_BREAK; // R9
            end
            default: begin
                nxt_emu_state = SMS_RUN;
            end
        endcase
    end

    // Reset returns to running, so a board with no emulator attached simply
    // executes; the cleared step history avoids a false step after reset.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            brk_sync_ff  <= 2'h0;
            stp_sync_ff  <= 2'h0;
            stp_prev_ff  <= 1'b0;
            emu_state_ff <= SMS_RUN;
        end else begin
            brk_sync_ff  <= nxt_brk_sync;
            stp_sync_ff  <= nxt_stp_sync;
            stp_prev_ff  <= nxt_stp_prev;
            emu_state_ff <= nxt_emu_state;
        end
    end

endmodule

// ===== rtl/sms_pkg.sv
package sms_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SYSTEM_CONTROL_ADDR      = 8'hb1;
    localparam logic [7:0] DATA_POINTER_SELECT_ADDR = 8'h92;
    localparam logic [7:0] POWER_CONTROL_SECOND_DEF = 8'h88;
    localparam logic [7:0] PORT5_DIRECTION_DEF      = 8'hf8;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int         SFR_MAP_SELECT_BIT   = 6;
    localparam logic [7:0] SYSTEM_CONTROL_RESET_ROM  = 8'h21;  // X010XX01, unknown bits as zero.
    localparam logic [7:0] SYSTEM_CONTROL_RESET_OTP  = 8'h21;  // X010X001, unknown bits as zero.
    localparam logic [7:0] SYSTEM_CONTROL_IMPL_ROM   = 8'h73;  // Bits that hold state on ROM parts.
    localparam logic [7:0] SYSTEM_CONTROL_IMPL_OTP   = 8'h77;  // Bits that hold state on OTP parts.
    localparam logic [7:0] DATA_POINTER_SELECT_RESET = 8'h00;  // XXXXX000.
    localparam logic [7:0] DATA_POINTER_SELECT_IMPL  = 8'h07;
    localparam int         SFR_COUNT_DEF        = 59;
    localparam int         REG_BANK_COUNT       = 4;

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sms_req_t;

    typedef struct packed {
        logic sel_standard;
        logic sel_power_control_second;
        logic sel_port5_direction;
    } sms_sel_t;

    typedef enum logic [1:0] {
        SMS_RUN   = 2'b00,
        SMS_BREAK = 2'b01,
        SMS_STEP  = 2'b10
    } sms_emu_t;

endpackage

// ===== dv/sms_monitor.sv
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Port checker for the map-select decode
// ------------------------------------------------------------------
module sms_monitor
    import sms_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire sms_req_t   cpu_req,
    input wire sms_sel_t   cpu_sel,
    input wire logic       sfr_map_select,
    input wire logic [7:0] cpu_rdata,
    input wire logic [2:0] data_pointer_select,
    input wire logic       cpu_run,
    input wire logic       emu_halted,
    input wire logic       emu_rd,
    input wire logic [7:0] emu_rdata
);
    // One domain, so clock and reset are given once for all properties.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> !sfr_map_select; endproperty
    property p_std; !sfr_map_select |-> cpu_sel == 3'b100; endproperty
    property p_pc2; sfr_map_select && cpu_req.addr == 8'h88 |-> cpu_sel == 3'b010; endproperty
    property p_p5; sfr_map_select && cpu_req.addr == 8'hf8 |-> cpu_sel == 3'b001; endproperty
    property p_oth; !(cpu_req.addr inside {8'h88, 8'hf8}) |-> cpu_sel == 3'b100; endproperty
    property p_hold;
        sfr_map_select && !(cpu_req.wr && cpu_req.addr == 8'hb1) |=> sfr_map_select;
    endproperty
    property p_wr; cpu_req.wr && cpu_req.addr == 8'hb1 |=> sfr_map_select == $past(cpu_req.wdata[6]);
    endproperty
    property p_rd;
        cpu_req.rd && !cpu_req.wr && cpu_req.addr == 8'hb1 |=> cpu_rdata[6] == $past(sfr_map_select);
    endproperty
    property p_dps;
        cpu_req.wr && cpu_req.addr == 8'h92 |=> data_pointer_select == $past(cpu_req.wdata[2:0]);
    endproperty
    // A readout request while the program runs must leave the readout data alone.
    property p_brk; !emu_halted && emu_rd |=> $stable(emu_rdata); endproperty
    a_rst: assert property (p_rst) else $error("map bit set after reset");
    a_std: assert property (p_std) else $error("standard decode lost");
    a_pc2: assert property (p_pc2) else $error("mapped power control decode");
    a_p5: assert property (p_p5) else $error("mapped port5 decode");
    a_oth: assert property (p_oth) else $error("other address left standard area");
    a_hold: assert property (p_hold) else $error("map bit cleared by hardware");
    a_wr: assert property (p_wr) else $error("map bit not written");
    a_rd: assert property (p_rd) else $error("map bit readback wrong");
    a_dps: assert property (p_dps) else $error("pointer select not written");
    a_brk: assert property (p_brk) else $error("readout taken while running");
    c_map: cover property (sfr_map_select && cpu_req.addr == 8'hf8);
    c_brk: cover property ($rose(emu_halted));
    c_dps: cover property (cpu_req.wr && cpu_req.addr == 8'h92);
    c_stp: cover property (emu_halted ##1 cpu_run);
endmodule

bind sms_sfr_area_map_select sms_monitor sms_monitor_inst (.clk_sys(clk_sys), .reset(reset),
    .cpu_req(cpu_req), .cpu_sel(cpu_sel), .sfr_map_select(sfr_map_select),
    .cpu_rdata(cpu_rdata), .data_pointer_select(data_pointer_select),
    .cpu_run(cpu_run), .emu_halted(emu_halted), .emu_rd(emu_rd), .emu_rdata(emu_rdata));

// ===== dv/sms_periph_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Peripheral read data seen behind the decode
// ------------------------------------------------------------------
module sms_periph_model (
    input  wire logic [7:0] addr,
    output logic [7:0]      periph_rdata
);
    // Address-derived data, so a stale or mis-steered read is visible.
    always_comb periph_rdata = addr ^ 8'h5a;
endmodule

// ===== dv/sms_sfr_area_map_select_tb.sv
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Register access bench
// ------------------------------------------------------------------
module sms_sfr_area_map_select_tb
    import sms_pkg::*;
;
    logic clk_sys, reset, brk, stp, erd;
    logic [7:0] prd, crd, erdat, eadr;
    logic [2:0] dps;
    logic map, run, halt;
    sms_req_t req;
    sms_sel_t csel;
    sms_sel_t esel;
    int n_mismatch, total_checks, i;

    sms_sfr_area_map_select sms_sfr_area_map_select_inst (.clk_sys(clk_sys), .reset(reset),
        .cpu_req(req), .cpu_sel(csel), .sfr_map_select(map), .periph_rdata(prd),
        .cpu_rdata(crd), .data_pointer_select(dps), .emu_break_pin(brk), .emu_step_pin(stp),
        .emu_rd_addr(eadr), .emu_rd(erd), .emu_sel(esel), .emu_rdata(erdat), .cpu_run(run),
        .emu_halted(halt));
    sms_periph_model sms_periph_model_inst (.addr(req.addr), .periph_rdata(prd));

    // Free-running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Requests change only at the falling edge, away from the sampling edge.
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{a, d, w, r};
    endtask
    task automatic rd(input logic [7:0] a);
        acc(1'b0, 1'b1, a, 8'h00);
        acc(1'b0, 1'b0, a, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait on a status output; running out counts against the run.
    task automatic wait_for(ref logic s);
        for (i = 0; i < 12 && s !== 1'b1; i++) @(negedge clk_sys);
        if (s !== 1'b1) begin
            chk("wait", 8'h00, 8'h01);
            final_report();
        end
    endtask

    initial begin
        n_mismatch = 0;
        total_checks = 0;
        reset = 1'b1;
        req = '0;
        brk = 1'b0;
        stp = 1'b0;
        erd = 1'b0;
        eadr = SYSTEM_CONTROL_ADDR;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        chk("run after reset", run, 8'h01);
        rd(8'hb1);
        chk("system control reset", crd, SYSTEM_CONTROL_RESET_ROM);
        rd(8'h92);
        chk("pointer select reset", crd, 8'h00);
        // A readout request while the program runs must be refused.
        erd = 1'b1;
        @(negedge clk_sys);
        erd = 1'b0;
        chk("emu refused", erdat, 8'h00);
        acc(1'b0, 1'b0, 8'h88, 8'h00);
        #1;
        chk("sel std", csel, 8'h04);
        acc(1'b1, 1'b0, 8'hb1, 8'hff);
        rd(8'hb1);
        chk("system control", crd, 8'h73);
        chk("map", map, 8'h01);
        acc(1'b0, 1'b0, 8'h88, 8'h00);
        #1;
        chk("sel pc2", csel, 8'h02);
        acc(1'b0, 1'b0, 8'hf8, 8'h00);
        #1;
        chk("sel p5", csel, 8'h01);
        acc(1'b0, 1'b0, 8'h92, 8'h00);
        #1;
        chk("sel dps", csel, 8'h04);
        repeat (20) @(negedge clk_sys);
        chk("map held", map, 8'h01);
        acc(1'b1, 1'b0, 8'h92, 8'hff);
        rd(8'h92);
        chk("pointer select", crd, 8'h07);
        chk("dps out", dps, 8'h07);
        rd(8'h10);
        chk("periph", crd, 8'h4a);
        brk = 1'b1;
        wait_for(halt);
        chk("halted run", run, 8'h00);
        erd = 1'b1;
        @(negedge clk_sys);
        erd = 1'b0;
        eadr = 8'h88;
        @(negedge clk_sys);
        chk("emu read", erdat, 8'h73);
        chk("emu sel pc2", esel, 8'h02);
        eadr = SYSTEM_CONTROL_ADDR;
        stp = 1'b1;
        wait_for(run);
        stp = 1'b0;
        @(negedge clk_sys);
        chk("step once", halt, 8'h01);
        brk = 1'b0;
        acc(1'b1, 1'b0, 8'hb1, 8'h00);
        rd(8'hb1);
        chk("map clear", map, 8'h00);
        chk("map readback", crd, 8'h00);
        // A reset in mid-run must restore the standard area.
        acc(1'b1, 1'b0, 8'hb1, 8'h40);
        acc(1'b0, 1'b0, 8'hb1, 8'h00);
        chk("map set again", map, 8'h01);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        chk("map after reset", map, 8'h00);
        rd(8'hb1);
        chk("system control again", crd, SYSTEM_CONTROL_RESET_ROM);
        final_report();
    end
endmodule
